// [verilog/acp_pkg.sv]
// constants, offsets and states of the serial configuration port
// assumes one core clock domain; pins are synchronised inside the port
package acp_pkg;

  localparam int          INSTR_BITS     = 16;
  localparam int          BYTE_BITS      = 8;
  localparam int          ADDR_W         = 13;
  localparam int          RW_BIT         = 15;
  localparam int          LEN_HI_BIT     = 14;
  localparam int          LEN_LO_BIT     = 13;
  localparam int          CFG_LSB_BIT    = 6;
  localparam int          NUM_SHADOW     = 17;

  localparam logic [12:0] ADDR_PORT_CFG  = 13'h0000;
  localparam logic [12:0] ADDR_CHAN_IDX  = 13'h0005;
  localparam logic [12:0] ADDR_SHADOW_LO = 13'h0008;
  localparam logic [12:0] ADDR_SHADOW_HI = 13'h0018;
  localparam logic [12:0] ADDR_XFER      = 13'h00FF;

  localparam logic [7:0]  RST_PORT_CFG   = 8'h00;
  localparam logic [7:0]  RST_CHAN_IDX   = 8'h03;
  localparam logic [7:0]  RST_SHADOW     = 8'h00;
  localparam logic [7:0]  XFER_GO        = 8'h01;

  localparam logic [1:0]  LEN_STREAM     = 2'h3;
  localparam logic [3:0]  INSTR_LAST     = 4'hF;
  localparam logic [3:0]  BYTE_LAST      = 4'h7;

  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_DATA  = 2'b01,
    ST_DONE  = 2'b10
  } acp_state_t;

endpackage

// [verilog/acp_reg_if.sv]
// byte access path between the serial engine and the register store
// assumes both ends run on the same core clock
interface acp_reg_if;
  logic                       wr_en;
  logic [acp_pkg::ADDR_W-1:0] addr;
  logic [7:0]                 wdata;
  logic [7:0]                 rdata;
  logic                       lsb_first;

  modport port (output wr_en, output addr, output wdata, input rdata, input lsb_first);
  modport regs (input wr_en, input addr, input wdata, output rdata, output lsb_first);
endinterface

// [verilog/acp_regs.sv]
// byte register store: port config, channel index, shadowed per-channel bank, transfer
// assumes single-cycle write strobes from the serial engine on core_clk
module acp_regs (
  input  wire logic                                   core_clk,
  input  wire logic                                   resetn,
  acp_reg_if.regs                                     bus,
  output logic [acp_pkg::NUM_SHADOW-1:0][7:0]         chan_a_cfg,
  output logic [acp_pkg::NUM_SHADOW-1:0][7:0]         chan_b_cfg
);
  import acp_pkg::*;

  logic [7:0]  port_cfg_q, port_cfg_d;
  logic [7:0]  chan_idx_q, chan_idx_d;
  logic        xfer_q, xfer_d;
  logic [7:0]  mas_a_q [NUM_SHADOW];
  logic [7:0]  mas_a_d [NUM_SHADOW];
  logic [7:0]  mas_b_q [NUM_SHADOW];
  logic [7:0]  mas_b_d [NUM_SHADOW];
  logic [7:0]  act_a_q [NUM_SHADOW];
  logic [7:0]  act_a_d [NUM_SHADOW];
  logic [7:0]  act_b_q [NUM_SHADOW];
  logic [7:0]  act_b_d [NUM_SHADOW];
  logic        in_shadow;
  logic [12:0] sh_off;
  logic [4:0]  sh_idx;

  assign in_shadow = (bus.addr >= ADDR_SHADOW_LO) && (bus.addr <= ADDR_SHADOW_HI);
  assign sh_off    = bus.addr - ADDR_SHADOW_LO;
  assign sh_idx    = sh_off[4:0];
  assign bus.lsb_first = port_cfg_q[CFG_LSB_BIT];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    port_cfg_d = port_cfg_q;
    chan_idx_d = chan_idx_q;
    if (bus.wr_en && bus.addr == ADDR_PORT_CFG) begin
      port_cfg_d = bus.wdata;
    end
    if (bus.wr_en && bus.addr == ADDR_CHAN_IDX) begin
      chan_idx_d = {6'h00, bus.wdata[1:0]};
    end
    xfer_d = bus.wr_en && bus.addr == ADDR_XFER && bus.wdata == XFER_GO;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      port_cfg_q <= RST_PORT_CFG;
      chan_idx_q <= RST_CHAN_IDX;
      xfer_q     <= 1'b0;
    end else begin
      port_cfg_q <= port_cfg_d;
      chan_idx_q <= chan_idx_d;
      xfer_q     <= xfer_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < NUM_SHADOW; i++) begin : g_shadow
    always_comb begin
      mas_a_d[i] = mas_a_q[i];
      mas_b_d[i] = mas_b_q[i];
      if (bus.wr_en && in_shadow && sh_idx == 5'(i)) begin
        if (chan_idx_q[0]) begin
          mas_a_d[i] = bus.wdata;
        end
        if (chan_idx_q[1]) begin
          mas_b_d[i] = bus.wdata;
        end
      end
      act_a_d[i] = xfer_q ? mas_a_q[i] : act_a_q[i];
      act_b_d[i] = xfer_q ? mas_b_q[i] : act_b_q[i];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        mas_a_q[i] <= RST_SHADOW;
        mas_b_q[i] <= RST_SHADOW;
        act_a_q[i] <= RST_SHADOW;
        act_b_q[i] <= RST_SHADOW;
      end else begin
        mas_a_q[i] <= mas_a_d[i];
        mas_b_q[i] <= mas_b_d[i];
        act_a_q[i] <= act_a_d[i];
        act_b_q[i] <= act_b_d[i];
      end
    end

    assign chan_a_cfg[i] = act_a_q[i];
    assign chan_b_cfg[i] = act_b_q[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    bus.rdata = 8'h00;
    if (bus.addr == ADDR_PORT_CFG) begin
      bus.rdata = port_cfg_q;
    end else if (bus.addr == ADDR_CHAN_IDX) begin
      bus.rdata = chan_idx_q;
    end else if (bus.addr == ADDR_XFER) begin
      bus.rdata = {7'h00, xfer_q};
    end else if (in_shadow) begin
      bus.rdata = chan_idx_q[0] ? mas_a_q[sh_idx] : mas_b_q[sh_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  cfg_order_a: assert property (
    bus.wr_en && bus.addr == ADDR_PORT_CFG |=> bus.lsb_first == $past(bus.wdata[CFG_LSB_BIT]))
    else $error("bit order select not taken from config write");

  xfer_apply_a: assert property (
    xfer_q |=> !xfer_q && act_a_q[0] == $past(mas_a_q[0]) && act_b_q[16] == $past(mas_b_q[16]))
    else $error("transfer did not update shadow and clear");

  shadow_hold_a: assert property (
    !xfer_q |=> act_a_q[3] == $past(act_a_q[3]) && act_b_q[3] == $past(act_b_q[3]))
    else $error("active register changed without transfer");

  chan_b_write_a: assert property (
    bus.wr_en && bus.addr == ADDR_SHADOW_LO && chan_idx_q[1] |=> mas_b_q[0] == $past(bus.wdata))
    else $error("selected channel b not written");

  chan_a_read_a: assert property (
    bus.addr == ADDR_SHADOW_HI && chan_idx_q[0] |-> bus.rdata == mas_a_q[16])
    else $error("read did not return channel a");

endmodule

// [verilog/acp_port.sv]
// three-wire serial configuration port: instruction decode, byte shifting, readback drive
// assumes sclk, chip select and data arrive asynchronously; sclk well below core_clk / 6
// Operation
// - all bits are shifted on edges of the host serial clock
// - chip select is active low; serial activity ignored while high
// - instruction capture starts at first sclk rise after select falls
// - select held low keeps port enabled, streaming continues
// - select high between bytes pauses a fixed-length frame, state kept; a streaming frame restarts
// - select never low: pins stay undriven, secondary static functions active
// - each frame opens with a sixteen bit instruction, then data
// - data phase length follows the two transfer length bits
// - data moves in whole bytes, one byte per register
// - first instruction bit (last bit when lsb first) selects read or write, decoded before data
// - on read the data pin turns to output at the data boundary
// - msb first after reset; lsb first selectable in port config
// - shadowed writes apply together on transfer write; transfer bit self-clears
// - per-channel writes go to every channel selected in channel index
// - per-channel read with both channels selected returns channel a
module acp_port (
  input  wire logic                                   core_clk,
  input  wire logic                                   resetn,
  input  wire logic                                   sclk_pin,
  input  wire logic                                   chip_select_n,
  input  wire logic                                   sdio_i,
  output logic                                        sdio_o,
  output logic                                        sdio_oe,
  output logic                                        static_mode,
  output logic                                        sec_dcs,
  output logic                                        sec_dfs,
  output logic [acp_pkg::NUM_SHADOW-1:0][7:0]         chan_a_cfg,
  output logic [acp_pkg::NUM_SHADOW-1:0][7:0]         chan_b_cfg
);
  import acp_pkg::*;

  acp_reg_if   rbus ();

  acp_regs u_regs (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .bus        (rbus.regs),
    .chan_a_cfg (chan_a_cfg),
    .chan_b_cfg (chan_b_cfg)
  );

  logic        sclk_m_q, sclk_s_q, sclk_p_q;
  logic        csn_m_q, csn_s_q;
  logic        din_m_q, din_s_q;
  acp_state_t  state_q, state_d;
  logic [15:0] shift_q, shift_d;
  logic [3:0]  bit_cnt_q, bit_cnt_d;
  logic [1:0]  bytes_q, bytes_d;
  logic [1:0]  len_q, len_d;
  logic        rd_q, rd_d;
  logic        ld_q, ld_d;
  logic [12:0] addr_q, addr_d;
  logic [7:0]  out_q, out_d;
  logic        sdo_q, sdo_d;
  logic        oe_q, oe_d;
  logic        seen_q, seen_d;
  logic        dcs_q, dcs_d;
  logic        dfs_q, dfs_d;
  logic        sclk_rise, sclk_fall, sel, lsb;
  logic        instr_done, byte_done;
  logic [15:0] sh_next;
  logic [7:0]  byte_in;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
      csn_m_q  <= 1'b1;
      csn_s_q  <= 1'b1;
      din_m_q  <= 1'b0;
      din_s_q  <= 1'b0;
    end else begin
      sclk_m_q <= sclk_pin;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      csn_m_q  <= chip_select_n;
      csn_s_q  <= csn_m_q;
      din_m_q  <= sdio_i;
      din_s_q  <= din_m_q;
    end
  end

  assign sclk_rise = sclk_s_q & ~sclk_p_q;
  assign sclk_fall = ~sclk_s_q & sclk_p_q;
  assign sel       = ~csn_s_q;
  assign lsb       = rbus.lsb_first;
  assign sh_next   = lsb ? {din_s_q, shift_q[15:1]} : {shift_q[14:0], din_s_q};
  assign byte_in   = lsb ? sh_next[15:8] : sh_next[7:0];

  assign rbus.addr  = addr_q;
  assign rbus.wdata = byte_in;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d    = state_q;
    shift_d    = shift_q;
    bit_cnt_d  = bit_cnt_q;
    bytes_d    = bytes_q;
    len_d      = len_q;
    rd_d       = rd_q;
    ld_d       = ld_q;
    addr_d     = addr_q;
    out_d      = out_q;
    sdo_d      = sdo_q;
    oe_d       = oe_q;
    instr_done = 1'b0;
    byte_done  = 1'b0;
    rbus.wr_en = 1'b0;
    seen_d     = seen_q | sel;
    dcs_d      = seen_q ? dcs_q : din_s_q;
    dfs_d      = seen_q ? dfs_q : sclk_s_q;
    if (!sel) begin
      oe_d = 1'b0;
      ld_d = 1'b0;
      if (!(state_q == ST_DATA && bit_cnt_q == 4'h0 && len_q != LEN_STREAM)) begin
        state_d   = ST_INSTR;
        bit_cnt_d = 4'h0;
        bytes_d   = 2'h0;
      end
    end else begin
      // turn pin to output for read data
      oe_d = (state_q == ST_DATA) && rd_q;
      if (ld_q) begin
        out_d = rbus.rdata;
        ld_d  = 1'b0;
      end
      if (sclk_rise) begin
        case (state_q)
          ST_INSTR: begin
            shift_d   = sh_next;
            bit_cnt_d = bit_cnt_q + 4'h1;
            if (bit_cnt_q == INSTR_LAST) begin
              instr_done = 1'b1;
              rd_d    = sh_next[RW_BIT];
              len_d   = sh_next[LEN_HI_BIT:LEN_LO_BIT];
              addr_d  = sh_next[ADDR_W-1:0];
              bytes_d = 2'h0;
              ld_d    = sh_next[RW_BIT];
              state_d = ST_DATA;
            end
          end
          ST_DATA: begin
            shift_d   = sh_next;
            bit_cnt_d = (bit_cnt_q == BYTE_LAST) ? 4'h0 : bit_cnt_q + 4'h1;
            if (bit_cnt_q == BYTE_LAST) begin
              byte_done  = 1'b1;
              rbus.wr_en = !rd_q;
              addr_d     = lsb ? addr_q + 13'h0001 : addr_q - 13'h0001;
              bytes_d    = bytes_q + 2'h1;
              if (len_q != LEN_STREAM && bytes_q == len_q) begin
                state_d = ST_DONE;
              end else begin
                ld_d = rd_q;
              end
            end
          end
          default: begin
          end
        endcase
      end
      if (sclk_fall && state_q == ST_DATA && rd_q) begin
        sdo_d = lsb ? out_q[0] : out_q[7];
        out_d = lsb ? {1'b0, out_q[7:1]} : {out_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= ST_INSTR;
      shift_q   <= 16'h0000;
      bit_cnt_q <= 4'h0;
      bytes_q   <= 2'h0;
      len_q     <= 2'h0;
      rd_q      <= 1'b0;
      ld_q      <= 1'b0;
      addr_q    <= 13'h0000;
      out_q     <= 8'h00;
      sdo_q     <= 1'b0;
      oe_q      <= 1'b0;
      seen_q    <= 1'b0;
      dcs_q     <= 1'b0;
      dfs_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      shift_q   <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      bytes_q   <= bytes_d;
      len_q     <= len_d;
      rd_q      <= rd_d;
      ld_q      <= ld_d;
      addr_q    <= addr_d;
      out_q     <= out_d;
      sdo_q     <= sdo_d;
      oe_q      <= oe_d;
      seen_q    <= seen_d;
      dcs_q     <= dcs_d;
      dfs_q     <= dfs_d;
    end
  end

  assign sdio_o      = sdo_q;
  assign sdio_oe     = oe_q;
  assign static_mode = ~seen_q;
  assign sec_dcs     = dcs_q;
  assign sec_dfs     = dfs_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  desel_release_a: assert property (
    !sel |=> !sdio_oe)
    else $error("data pin driven while deselected");

  static_float_a: assert property (
    static_mode |-> !sdio_oe)
    else $error("data pin driven in static mode");

  instr_count_a: assert property (
    instr_done |-> bit_cnt_q == 4'hF && state_q == ST_INSTR)
    else $error("instruction not sixteen bits");

  first_bit_a: assert property (
    sel && sclk_rise && state_q == ST_INSTR |=> bit_cnt_q == $past(bit_cnt_q) + 4'h1)
    else $error("instruction bit not captured on rise");

  rw_decode_a: assert property (
    instr_done && sh_next[15] |=> state_q == ST_DATA && rd_q ##1 sdio_oe || !sel)
    else $error("read not decoded at boundary");

  read_drive_a: assert property (
    sel && state_q == ST_DATA && rd_q |=> sdio_oe)
    else $error("read data not driven");

  len_end_a: assert property (
    byte_done && len_q != 2'h3 && bytes_q == len_q |=> state_q == ST_DONE)
    else $error("data phase length not honoured");

  addr_step_a: assert property (
    byte_done |=> addr_q == ($past(lsb) ? $past(addr_q) + 13'h0001 : $past(addr_q) - 13'h0001))
    else $error("address not stepped after byte");

  stall_keep_a: assert property (
    !sel && state_q == ST_DATA && bit_cnt_q == 4'h0 && len_q != 2'h3 |=> state_q == ST_DATA && $stable(addr_q))
    else $error("frame state lost during stall");

  stream_on_a: assert property (
    sel && state_q == ST_DATA && len_q == 2'h3 |=> state_q == ST_DATA)
    else $error("streaming frame ended with select low");

endmodule

// [verification/acp_host_model.sv]
// host side of the serial configuration port: drives clock, select and data pin
// assumes the core clock paces it; one serial bit spans eight core cycles (400 ns)
module acp_host_model (
  input  wire logic core_clk,
  output logic      sclk_pin,
  output logic      chip_select_n,
  output wire logic sdio_i,
  input  wire logic sdio_o,
  input  wire logic sdio_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  logic drv_en;
  logic drv_bit;
  logic float_q = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // pin level from both drivers
  assign sdio_i = sdio_oe ? sdio_o : (drv_en ? drv_bit : float_q);

  // released pin shows a pattern that changes every cycle
  always @(posedge core_clk) float_q <= ~float_q;

  initial begin
    sclk_pin      = 1'b0;
    chip_select_n = 1'b1;
    drv_en        = 1'b1;
    drv_bit       = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // select low opens the cycle
  task automatic cs_low();
    @(posedge core_clk);
    chip_select_n <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  // clock parked low, then select high
  task automatic cs_high();
    @(posedge core_clk);
    sclk_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    chip_select_n <= 1'b1;
    drv_en        <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic set_pins(input logic c, input logic d);
    @(posedge core_clk);
    sclk_pin <= c;
    drv_en   <= 1'b1;
    drv_bit  <= d;
    repeat (6) @(posedge core_clk);
  endtask

  // eight bits, data set while clock low
  task automatic shift_byte(input logic [7:0] b, input bit lsb, input bit rd,
                            output logic [7:0] r, output logic [7:0] oe);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      sclk_pin <= 1'b0;
      drv_en   <= !rd;
      drv_bit  <= lsb ? b[i] : b[7-i];
      repeat (4) @(posedge core_clk);
      sclk_pin <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      r[lsb ? i : 7-i]  = sdio_i;
      oe[lsb ? i : 7-i] = sdio_oe;
      @(posedge core_clk);
    end
  endtask

  task automatic instr(input logic rd, input logic [1:0] len, input logic [12:0] a, input bit lsb);
    logic [15:0] w;
    logic [7:0]  r;
    logic [7:0]  o;
    w = {rd, len, a};
    shift_byte(lsb ? w[7:0] : w[15:8], lsb, 1'b0, r, o);
    shift_byte(lsb ? w[15:8] : w[7:0], lsb, 1'b0, r, o);
  endtask
endmodule

// [verification/tb.sv]
// self-checking bench for the serial configuration port
// assumes the host model paces the link; core clock 50 ns, link bit 400 ns
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import acp_pkg::*;

  logic                       core_clk;
  logic                       resetn = 1'b0;
  logic                       sclk_pin;
  logic                       chip_select_n;
  logic                       sdio_i;
  logic                       sdio_o;
  logic                       sdio_oe;
  logic                       static_mode;
  logic                       sec_dcs;
  logic                       sec_dfs;
  logic [NUM_SHADOW-1:0][7:0] chan_a_cfg;
  logic [NUM_SHADOW-1:0][7:0] chan_b_cfg;
  bit                         lsb_mode;
  int                         bad_count;
  int                         total_checks;

  ////////////////////////////////////////////////////////////////////////////////
  acp_port acp_port_inst (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .sclk_pin      (sclk_pin),
    .chip_select_n (chip_select_n),
    .sdio_i        (sdio_i),
    .sdio_o        (sdio_o),
    .sdio_oe       (sdio_oe),
    .static_mode   (static_mode),
    .sec_dcs       (sec_dcs),
    .sec_dfs       (sec_dfs),
    .chan_a_cfg    (chan_a_cfg),
    .chan_b_cfg    (chan_b_cfg)
  );

  acp_host_model acp_host_model_inst (
    .core_clk      (core_clk),
    .sclk_pin      (sclk_pin),
    .chip_select_n (chip_select_n),
    .sdio_i        (sdio_i),
    .sdio_o        (sdio_o),
    .sdio_oe       (sdio_oe)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one frame: instruction, n bytes, optional select pause between bytes
  task automatic xfer(input logic rdn, input logic [1:0] len, input logic [12:0] a, input int n,
                      input logic [7:0] d [4], input bit pause);
    logic [7:0] r;
    logic [7:0] o;
    acp_host_model_inst.cs_low();
    acp_host_model_inst.instr(rdn, len, a, lsb_mode);
    for (int i = 0; i < n; i++) begin
      if (pause && i > 0) begin
        acp_host_model_inst.cs_high();
        acp_host_model_inst.cs_low();
      end
      acp_host_model_inst.shift_byte(d[i], lsb_mode, rdn, r, o);
      check(o, rdn ? 8'hFF : 8'h00);
      if (rdn) check(r, d[i]);
    end
    acp_host_model_inst.cs_high();
    check({7'h00, sdio_oe}, 8'h00);
  endtask

  task automatic wr1(input logic [12:0] a, input logic [7:0] v);
    xfer(1'b0, 2'h0, a, 1, '{v, 8'h00, 8'h00, 8'h00}, 1'b0);
  endtask

  task automatic rd1(input logic [12:0] a, input logic [7:0] v);
    xfer(1'b1, 2'h0, a, 1, '{v, 8'h00, 8'h00, 8'h00}, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    lsb_mode = 1'b0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      acp_host_model_inst.set_pins(i[1], i[0]);
      check({6'h00, sec_dfs, sec_dcs}, i[7:0]);
      check({7'h00, static_mode}, 8'h01);
    end
    acp_host_model_inst.set_pins(1'b0, 1'b0);
    rd1(13'h0005, 8'h03);
    check({7'h00, static_mode}, 8'h00);
    acp_host_model_inst.set_pins(1'b1, 1'b1);
    check({6'h00, sec_dfs, sec_dcs}, 8'h00);
    acp_host_model_inst.set_pins(1'b0, 1'b0);
    rd1(13'h0000, 8'h00);
    wr1(13'h0030, 8'h5A);
    rd1(13'h0030, 8'h00);
    wr1(13'h0008, 8'hA5);
    check(chan_a_cfg[0], 8'h00);
    wr1(13'h00FF, 8'h01);
    check(chan_a_cfg[0], 8'hA5);
    check(chan_b_cfg[0], 8'hA5);
    rd1(13'h00FF, 8'h00);
    xfer(1'b0, 2'h2, 13'h000A, 3, '{8'h11, 8'h22, 8'h33, 8'h00}, 1'b0);
    xfer(1'b1, 2'h2, 13'h000A, 3, '{8'h11, 8'h22, 8'h33, 8'h00}, 1'b0);
    xfer(1'b1, 2'h3, 13'h000A, 4, '{8'h11, 8'h22, 8'h33, 8'h00}, 1'b0);
    xfer(1'b0, 2'h1, 13'h000C, 2, '{8'h66, 8'h77, 8'h00, 8'h00}, 1'b1);
    xfer(1'b0, 2'h0, 13'h000D, 2, '{8'h12, 8'h34, 8'h00, 8'h00}, 1'b0);
    wr1(13'h00FF, 8'h01);
    check(chan_a_cfg[4], 8'h66);
    check(chan_a_cfg[3], 8'h77);
    check(chan_a_cfg[5], 8'h12);
    check(chan_b_cfg[2], 8'h11);
    wr1(13'h0005, 8'h01);
    wr1(13'h0009, 8'h44);
    wr1(13'h0005, 8'h02);
    wr1(13'h0009, 8'h55);
    wr1(13'h0005, 8'h03);
    wr1(13'h00FF, 8'h01);
    check(chan_a_cfg[1], 8'h44);
    check(chan_b_cfg[1], 8'h55);
    rd1(13'h0009, 8'h44);
    wr1(13'h0000, 8'h40);
    lsb_mode = 1'b1;
    xfer(1'b0, 2'h1, 13'h0010, 2, '{8'h88, 8'h99, 8'h00, 8'h00}, 1'b0);
    wr1(13'h00FF, 8'h01);
    check(chan_a_cfg[8], 8'h88);
    check(chan_a_cfg[9], 8'h99);
    rd1(13'h0000, 8'h40);
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
